// ---- uart_mdf_pkg.sv ----
// Package: register map, field layouts and carriers for the multi-drop address filter
package uart_mdf_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_P0_OWN_ADDR = 8'ha9; // port0_own_address
	localparam logic [7:0] OFF_P0_ADDR_MASK = 8'hb9; // port0_address_mask
	localparam logic [7:0] OFF_P1_ADDR_MASK = 8'hba; // port1_address_mask
	localparam logic [7:0] OFF_P1_OWN_ADDR = 8'hbb; // port1_own_address
	localparam logic [7:0] OFF_CTRL0 = 8'hc0; // serial_control_reg, port 0
	localparam logic [7:0] OFF_CTRL1 = 8'hc4; // serial_control_reg, port 1
	localparam logic [7:0] OFF_IRQ_STATUS = 8'hc8; // sticky event flags
	localparam logic [7:0] OFF_IRQ_MASK = 8'hcc; // event enables
	localparam logic [7:0] OFF_RX_DATA0 = 8'hd0; // last accepted frame, port 0
	localparam logic [7:0] OFF_RX_DATA1 = 8'hd4; // last accepted frame, port 1

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_MODE_LSB = 6; // mode field [7:6]
	localparam int CTRL_FILTER_BIT = 5; // addr_filter_enable
	localparam int RXD_NINTH_BIT = 8; // ninth bit within rx data word
	localparam int IRQ_DONE0_BIT = 0; // receive_done_flag, port 0
	localparam int IRQ_DONE1_BIT = 1; // receive_done_flag, port 1
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam logic [8:0] RXD_RESET = 9'h000; // last accepted frame
	localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

	// ----------------------------------------
	// Serial modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_SYNC = 2'h0, // mode 0
		MODE_8BIT = 2'h1, // mode 1
		MODE_9BIT_FIX = 2'h2, // mode 2
		MODE_9BIT_VAR = 2'h3 // mode 3
	} uart_mode_t;

	// Frame handed over by the receiver core
	typedef struct packed {
		logic [7:0] data; // received byte
		logic ninth; // ninth bit, or stop bit in mode 1
	} rx_frame_t;

	// Filter setup of one port
	typedef struct packed {
		uart_mode_t mode;
		logic filterEn;
		logic [7:0] ownAddr;
		logic [7:0] addrMask;
	} port_cfg_t;

endpackage : uart_mdf_pkg

// ---- uart_addr_match.sv ----
// Address comparison and accept decision for one serial port
`timescale 1ns/10ps
module uart_addr_match import uart_mdf_pkg::*; (
	input wire port_cfg_t cfg,
	input wire rx_frame_t frame,
	output logic accept
);

	// ----------------------------------------
	// Match helpers
	// ----------------------------------------
	// Given address: only mask-one positions compared
	function automatic logic givenHit(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] d);
		givenHit = ((d ^ a) & m) == ADDR_RESET;
	endfunction : givenHit

	// Broadcast: OR of address and mask, its zeros are don't-care
	function automatic logic bcastHit(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] d);
		bcastHit = ((~d) & (a | m)) == ADDR_RESET;
	endfunction : bcastHit

	// ----------------------------------------
	// Accept decision
	// ----------------------------------------
	always_comb begin
		logic hit;
		hit = givenHit(cfg.ownAddr, cfg.addrMask, frame.data) |
			bcastHit(cfg.ownAddr, cfg.addrMask, frame.data);
		case (cfg.mode)
			MODE_SYNC: begin
				accept = 1'b1; // Filter bit ignored in mode 0
			end
			MODE_8BIT: begin
				// Stop bit stands in for the ninth bit
				accept = !cfg.filterEn || (frame.ninth && hit);
			end
			MODE_9BIT_FIX, MODE_9BIT_VAR: begin
				// Data frames (ninth zero) dropped while filtering
				accept = !cfg.filterEn || (frame.ninth && hit);
			end
			default: begin
				accept = 1'b1;
			end
		endcase
	end

endmodule : uart_addr_match

// ---- uart_multidrop_address_filter.sv ----
// Multi-drop receive address filter for two serial ports with Wishbone registers
`timescale 1ns/10ps
module uart_multidrop_address_filter import uart_mdf_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Frames from the two receiver cores, same clock
	input wire logic rxValid0,
	input wire rx_frame_t rxFrame0,
	input wire logic rxValid1,
	input wire rx_frame_t rxFrame1,
	// Level interrupt
	output logic irq
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] own0_reg, own0_next; // port0_own_address
	logic [7:0] mask0_reg, mask0_next; // port0_address_mask
	logic [7:0] own1_reg, own1_next; // port1_own_address
	logic [7:0] mask1_reg, mask1_next; // port1_address_mask
	logic [7:0] ctrl0_reg, ctrl0_next; // serial_control_reg port 0
	logic [7:0] ctrl1_reg, ctrl1_next; // serial_control_reg port 1
	logic [1:0] status_reg, status_next; // receive_done_flag per port
	logic [1:0] irqMask_reg, irqMask_next; // interrupt enables
	logic [8:0] rxData0_reg, rxData0_next; // accepted frame, port 0
	logic [8:0] rxData1_reg, rxData1_next; // accepted frame, port 1
	logic ack_reg, ack_next; // bus acknowledge
	logic err_reg, err_next; // bus error for unmapped address
	logic [31:0] rdata_reg, rdata_next; // bus read data

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic req; // new request this cycle
	logic wrEn; // write strobe into low byte
	logic mapped; // address hits a register
	port_cfg_t cfg0, cfg1; // per-port filter setup
	logic accept0, accept1; // filter decisions
	logic done0, done1; // accepted frame events

	// Ack drops the cycle after it was given, so one request one answer
	assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
	assign wrEn = req && wb_we_i && wb_sel_i[0] && mapped;

	// Address decoder
	always_comb begin
		case (wb_adr_i)
			OFF_P0_OWN_ADDR, OFF_P0_ADDR_MASK, OFF_P1_ADDR_MASK, OFF_P1_OWN_ADDR,
			OFF_CTRL0, OFF_CTRL1, OFF_IRQ_STATUS, OFF_IRQ_MASK,
			OFF_RX_DATA0, OFF_RX_DATA1: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Filter instances
	// ----------------------------------------
	// Control bits [7:6] mode, bit 5 filter enable
	assign cfg0 = '{mode: uart_mode_t'(ctrl0_reg[CTRL_MODE_LSB +: $bits(uart_mode_t)]),
		filterEn: ctrl0_reg[CTRL_FILTER_BIT], ownAddr: own0_reg, addrMask: mask0_reg};
	assign cfg1 = '{mode: uart_mode_t'(ctrl1_reg[CTRL_MODE_LSB +: $bits(uart_mode_t)]),
		filterEn: ctrl1_reg[CTRL_FILTER_BIT], ownAddr: own1_reg, addrMask: mask1_reg};

	uart_addr_match port0Match (
		.cfg(cfg0),
		.frame(rxFrame0),
		.accept(accept0)
	);

	uart_addr_match port1Match (
		.cfg(cfg1),
		.frame(rxFrame1),
		.accept(accept1)
	);

	// A frame only raises done when the filter lets it through
	assign done0 = rxValid0 && accept0;
	assign done1 = rxValid1 && accept1;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Software-owned bytes; writes to status and data registers fall through
	always_comb begin
		// Hold by default
		own0_next = own0_reg;
		mask0_next = mask0_reg;
		own1_next = own1_reg;
		mask1_next = mask1_reg;
		ctrl0_next = ctrl0_reg;
		ctrl1_next = ctrl1_reg;
		irqMask_next = irqMask_reg;
		// A write with lane 0 off is acked but changes nothing
		if (wrEn) begin
			case (wb_adr_i)
				OFF_P0_OWN_ADDR: begin
					// Port 0 own address
					own0_next = wb_dat_i[7:0];
				end
				OFF_P0_ADDR_MASK: begin
					// Port 0 mask, ones mark compared bits
					mask0_next = wb_dat_i[7:0];
				end
				OFF_P1_ADDR_MASK: begin
					// Port 1 keeps its own mask
					mask1_next = wb_dat_i[7:0];
				end
				OFF_P1_OWN_ADDR: begin
					// Port 1 keeps its own address
					own1_next = wb_dat_i[7:0];
				end
				OFF_CTRL0: begin
					// Mode and filter enable, port 0
					ctrl0_next = wb_dat_i[7:0];
				end
				OFF_CTRL1: begin
					// Mode and filter enable, port 1
					ctrl1_next = wb_dat_i[7:0];
				end
				OFF_IRQ_MASK: begin
					// One enable per done flag
					irqMask_next = wb_dat_i[1:0];
				end
				default: begin
					// Status, data and unmapped offsets leave setup alone
				end
			endcase
		end
	end

	// Addresses and masks clear so every address matches after reset
	always_ff @(posedge core_clk) begin
		if (srst) begin
			own0_reg <= ADDR_RESET;
			mask0_reg <= ADDR_RESET;
			// Port 1 clears the same way, so it also matches everything
			own1_reg <= ADDR_RESET;
			mask1_reg <= ADDR_RESET;
			ctrl0_reg <= CTRL_RESET;
			ctrl1_reg <= CTRL_RESET;
			irqMask_reg <= IRQ_RESET;
		end else begin
			own0_reg <= own0_next;
			mask0_reg <= mask0_next;
			own1_reg <= own1_next;
			mask1_reg <= mask1_next;
			ctrl0_reg <= ctrl0_next;
			ctrl1_reg <= ctrl1_next;
			irqMask_reg <= irqMask_next;
		end
	end

	// ----------------------------------------
	// Receive events
	// ----------------------------------------
	// Done flags and the last accepted frame of each port
	always_comb begin
		// Hold by default
		status_next = status_reg;
		rxData0_next = rxData0_reg;
		rxData1_next = rxData1_reg;
		// Write one to clear, low byte lane only
		if (wrEn && (wb_adr_i == OFF_IRQ_STATUS)) begin
			// Zeros written leave their flag alone
			status_next = status_reg & ~wb_dat_i[1:0];
		end
		// Hardware set after the clear so a coincident event wins
		if (done0) begin
			status_next[IRQ_DONE0_BIT] = 1'b1;
			// Whole frame kept, ninth bit on top
			rxData0_next = {rxFrame0.ninth, rxFrame0.data};
		end
		// Port 1 follows the same path
		if (done1) begin
			status_next[IRQ_DONE1_BIT] = 1'b1;
			rxData1_next = {rxFrame1.ninth, rxFrame1.data};
		end
	end

	// No queue: a second frame before software reads overwrites the first
	always_ff @(posedge core_clk) begin
		if (srst) begin
			status_reg <= IRQ_RESET;
			rxData0_reg <= RXD_RESET;
			rxData1_reg <= RXD_RESET;
		end else begin
			status_reg <= status_next;
			rxData0_reg <= rxData0_next;
			rxData1_reg <= rxData1_next;
		end
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	// One cycle to answer; read data then stands until the next read
	always_comb begin
		ack_next = req && mapped;
		err_next = req && !mapped;
		rdata_next = rdata_reg;
		// Reads zero-extend each register into the low bits
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				OFF_P0_OWN_ADDR: begin
					// Setup bytes read back as written
					rdata_next = 32'(own0_reg);
				end
				OFF_P0_ADDR_MASK: begin
					// Port 0 mask
					rdata_next = 32'(mask0_reg);
				end
				OFF_P1_ADDR_MASK: begin
					// Port 1 mask
					rdata_next = 32'(mask1_reg);
				end
				OFF_P1_OWN_ADDR: begin
					// Port 1 own address
					rdata_next = 32'(own1_reg);
				end
				OFF_CTRL0: begin
					// Port 0 control
					rdata_next = 32'(ctrl0_reg);
				end
				OFF_CTRL1: begin
					// Port 1 control
					rdata_next = 32'(ctrl1_reg);
				end
				OFF_IRQ_STATUS: begin
					// Flags as they stand, before this cycle's events
					rdata_next = 32'(status_reg);
				end
				OFF_IRQ_MASK: begin
					// Interrupt enables
					rdata_next = 32'(irqMask_reg);
				end
				OFF_RX_DATA0: begin
					// Ninth bit lands just above the byte
					rdata_next = 32'(rxData0_reg);
				end
				OFF_RX_DATA1: begin
					// Same layout for port 1
					rdata_next = 32'(rxData1_reg);
				end
				default: begin
					// Unmapped reads return zero alongside err
					rdata_next = BUS_ZERO;
				end
			endcase
		end
	end

	// Answer registers; ack never stands two cycles because req needs it low
	always_ff @(posedge core_clk) begin
		if (srst) begin
			// No answer pending and read data cleared
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= BUS_ZERO;
		end else begin
			ack_reg <= ack_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = rdata_reg;
	// Level interrupt while any unmasked done flag stands
	assign irq = |(status_reg & irqMask_reg);

endmodule : uart_multidrop_address_filter

// ---- uart_node_model.sv ----
// Far-side serial node: hands completed frames to one receive port
`timescale 1ns/10ps
module uart_node_model import uart_mdf_pkg::*; (
	input wire logic core_clk,
	input wire logic send,
	input wire logic [8:0] word,
	output logic valid,
	output rx_frame_t frame
);
	// One-cycle frame pulse; word is {data, ninth} as the master sends it
	always_ff @(posedge core_clk) begin
		valid <= send;
		// Idle frame toggles, so a stale byte never looks valid
		frame <= send ? rx_frame_t'(word) : rx_frame_t'(~frame);
	end
endmodule : uart_node_model

// ---- uart_mdf_chk.sv ----
// Port-level checker for the multi-drop address filter
`timescale 1ns/10ps
module uart_mdf_chk import uart_mdf_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	input logic wb_err_o,
	input wire logic rxValid0,
	input wire logic rxValid1,
	input logic irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// Decoded map, so ack and err can be tied to the address
	wire logic mapped = wb_adr_i inside {OFF_P0_OWN_ADDR, OFF_P0_ADDR_MASK,
		OFF_P1_ADDR_MASK, OFF_P1_OWN_ADDR, OFF_CTRL0, OFF_CTRL1, OFF_IRQ_STATUS,
		OFF_IRQ_MASK, OFF_RX_DATA0, OFF_RX_DATA1};
	sequence busReq;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence busAns;
		##1 (wb_ack_o ^ wb_err_o);
	endsequence
	ans_once_a: assert property (busReq |-> busAns)
		else $error("bus answer late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	err_pulse_a: assert property (wb_err_o |=> !wb_err_o)
		else $error("err too long");
	ack_mapped_a: assert property (wb_ack_o |-> $past(mapped))
		else $error("ack on unmapped");
	err_unmapped_a: assert property (wb_err_o |-> !$past(mapped))
		else $error("err on mapped");
	irq_rise_a: assert property ($rose(irq) |-> $past(rxValid0 || rxValid1 || wb_we_i))
		else $error("irq rose uncaused");
	irq_fall_a: assert property ($fell(irq) |-> $past(wb_cyc_i && wb_we_i))
		else $error("irq fell uncaused");
	rst_clear_a: assert property (disable iff (1'b0) srst |=> !wb_ack_o && !irq)
		else $error("reset left outputs");
	dat_hold_a: assert property ($changed(wb_dat_o) |->
		((wb_ack_o || wb_err_o) && !$past(wb_we_i)) || $past(srst))
		else $error("read data moved");
endmodule : uart_mdf_chk
bind uart_multidrop_address_filter uart_mdf_chk chk (.core_clk(core_clk), .srst(srst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.rxValid0(rxValid0), .rxValid1(rxValid1), .irq(irq));

// ---- test_uart_multidrop_address_filter.sv ----
// Self-checking bench for the multi-drop address filter
`timescale 1ns/10ps
module test_uart_multidrop_address_filter import uart_mdf_pkg::*;;
	logic core_clk = 1'h0, srst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, gotErr;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0, datO, rdat;
	logic ack, err, irq, v0, v1;
	logic [1:0] send = 2'h0;
	logic [3:0] sel = 4'hf;
	logic [8:0] word = 9'h0;
	logic [27:0] t;
	rx_frame_t f0, f1;
	int errors = 0, n_compared = 0, k;
	localparam logic [7:0] REGS [4] = '{OFF_P0_OWN_ADDR, OFF_P0_ADDR_MASK,
		OFF_P1_OWN_ADDR, OFF_P1_ADDR_MASK};
	localparam logic [7:0] VALS [4] = '{8'hc0, 8'hfd, 8'he0, 8'hfa};
	// Port, control, byte, ninth bit, accept
	// Last three: address, data with filter off, data with filter back on
	localparam logic [27:0] TBL [13] = '{28'h0a05500, 28'h0a0c211, 28'h0a0c110,
		28'h0a0ff11, 28'h0805501, 28'h0205501, 28'h060c200, 28'h060c211,
		28'h1e0e511, 28'h1e0c010,
		28'h0e0c211, 28'h0c05501, 28'h0e05500};
	always #20 core_clk = ~core_clk;
	uart_multidrop_address_filter dut (.core_clk(core_clk), .srst(srst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
		.wb_err_o(err), .rxValid0(v0), .rxFrame0(f0), .rxValid1(v1),
		.rxFrame1(f1), .irq(irq));
	uart_node_model node0 (.core_clk(core_clk), .send(send[0]), .word(word),
		.valid(v0), .frame(f0));
	uart_node_model node1 (.core_clk(core_clk), .send(send[1]), .word(word),
		.valid(v1), .frame(f1));
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task print_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	// Classic cycle held until ack or err is sampled high
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (i = 0; i < 16; i++) begin
			@(posedge core_clk);
			if (ack === 1'h1 || err === 1'h1)
				break;
		end
		if (i == 16) begin
			errors++;
			print_verdict();
		end
		rdat = datO;
		gotErr = err;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask : bus
	// One frame on port p, then room for the flag to land
	task frame(input logic p, input logic [8:0] w);
		@(posedge core_clk);
		word <= w;
		send[p] <= 1'h1;
		@(posedge core_clk);
		send <= 2'h0;
		repeat (2) @(posedge core_clk);
	endtask : frame
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'h0;
		for (k = 0; k < 4; k++) begin
			bus(1'h0, REGS[k], BUS_ZERO);
			check(rdat, BUS_ZERO, "reset value");
			bus(1'h1, REGS[k], {24'h0, VALS[k]});
			bus(1'h0, REGS[k], BUS_ZERO);
			check(rdat, {24'h0, VALS[k]}, "address reg");
		end
		bus(1'h0, 8'he0, BUS_ZERO);
		check({31'h0, gotErr}, 32'h1, "unmapped");
		// Low lane off: write is acked but the address stays
		sel <= 4'he;
		bus(1'h1, OFF_P0_OWN_ADDR, 32'h55);
		sel <= 4'hf;
		bus(1'h0, OFF_P0_OWN_ADDR, BUS_ZERO);
		check(rdat, {24'h0, VALS[0]}, "lane off");
		bus(1'h1, OFF_IRQ_MASK, 32'h3);
		for (k = 0; k < 13; k++) begin
			t = TBL[k];
			bus(1'h1, t[24] ? OFF_CTRL1 : OFF_CTRL0, {24'h0, t[23:16]});
			frame(t[24], {t[15:8], t[4]});
			bus(1'h0, OFF_IRQ_STATUS, BUS_ZERO);
			check(rdat, {30'h0, t[0] & t[24], t[0] & ~t[24]}, "done");
			check({31'h0, irq}, {31'h0, t[0]}, "irq");
			if (t[0]) begin
				bus(1'h0, t[24] ? OFF_RX_DATA1 : OFF_RX_DATA0, BUS_ZERO);
				check(rdat, {23'h0, t[4], t[15:8]}, "rx data");
			end
			bus(1'h1, OFF_IRQ_STATUS, 32'h3);
			@(posedge core_clk);
			check({31'h0, irq}, 32'h0, "irq clear");
		end
		// Port 0 masked: flag still sets, irq stays low
		bus(1'h1, OFF_IRQ_MASK, 32'h2);
		bus(1'h1, OFF_CTRL0, BUS_ZERO);
		frame(1'h0, 9'h0aa);
		check({31'h0, irq}, 32'h0, "masked irq");
		bus(1'h0, OFF_IRQ_STATUS, BUS_ZERO);
		check(rdat, 32'h1, "masked done");
		print_verdict();
	end
endmodule : test_uart_multidrop_address_filter
